/* File: design/rtccal_pkg.sv */
// Purpose: shared constants for the calendar, trim and weekly alarm block
// Assumes: byte-wide register file behind the serial engine, 25 MHz clk
// Notes: offsets are register indices of the byte-wide register port
package rtccal_pkg;
  // register offsets
  localparam logic [3:0] ADDR_SEC = 4'h0;
  localparam logic [3:0] ADDR_MIN = 4'h1;
  localparam logic [3:0] ADDR_HOUR = 4'h2;
  localparam logic [3:0] ADDR_WDAY = 4'h3;
  localparam logic [3:0] ADDR_DAY = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR = 4'h6;
  localparam logic [3:0] ADDR_TRIM = 4'h7;
  localparam logic [3:0] ADDR_WMIN = 4'h8;
  localparam logic [3:0] ADDR_WHOUR = 4'h9;
  localparam logic [3:0] ADDR_WDAYS = 4'hA;
  // writable bit masks, unused bits read zero
  localparam logic [7:0] MASK_SEC = 8'h7F;
  localparam logic [7:0] MASK_MIN = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_DAY = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h9F;
  localparam logic [7:0] MASK_WDAYS = 8'h7F;
  // field positions
  localparam int CENTURY_BIT = 7;
  localparam int TRIM_SEL_BIT = 7;
  localparam int TRIM_DIR_BIT = 6;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE = 8'h01;
  // alarm flag delay after a match
  localparam int MATCH_DELAY_US = 31;
  localparam int CLK_MHZ = 25;
  localparam int MATCH_DELAY_CYC = MATCH_DELAY_US * CLK_MHZ;
  localparam logic [9:0] MATCH_LOAD = 10'(MATCH_DELAY_CYC - 1);
endpackage

/* File: design/rtccal_top.sv */
// Purpose: calendar counters, second trim and weekly alarm of a serial RTC
// Assumes: register port driven by the serial engine on clk; osc_clk is the 32.768 kHz oscillator clock
// Notes: seconds, minutes, hours and weekday are kept here so that carries, trim slots and alarm work
// Operation
// - day limit follows month and leap year
// - past last day, day to 1, month up
// - months 1..12, past 12 year increments
// - BCD year 00..99, multiples of four leap
// - century bit flips on year wrap
// - all counters held in BCD fields
// - power-up flag clears trim register
// - interval select 0 trims seconds 00,20,40
// - interval select 1 trims second 00
// - trim write skips the coinciding slot
// - direction 0 lengthens by (value-1)*2
// - direction 1 shortens by (~value+1)*2
// - trim bits five..one zero, no correction
// - second is 32768 counts, trim alters it
// - trim never touches the oscillator clock
// - alarm hour bit 5 is PM or twenties
// - 12-hour mode, 12 midnight, 32 noon
// - day enables map to weekday 0..6
// - no day enabled, never a match
// - flag valid when enabled, set after 31us
// - weekday advances mod seven on hour carry
`timescale 1ns/1ps
`default_nettype none
module rtccal_top #(
  parameter int SEC_COUNTS = 32768 // oscillator counts in one plain second
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic osc_clk,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic hour_mode_12,
  input wire logic power_up_flag,
  input wire logic week_alarm_enable,
  input wire logic walarm_flag_clear,
  output logic [7:0] reg_rd_data,
  output logic walarm_flag
);
  import rtccal_pkg::*;
  localparam logic [15:0] BASE_LEN = 16'(SEC_COUNTS); // untrimmed second length
  // clk domain state
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [2:0] wday;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] trim;
    logic [7:0] wmin;
    logic [7:0] whour;
    logic [7:0] wdays;
    logic tick_s1; // first sync stage, read by tick_s2 only
    logic tick_s2;
    logic tick_s3;
    logic [15:0] sec_len; // length of the running second, read by osc domain
    logic trim_written; // trim write seen in this second
    logic match_prev;
    logic match_pending;
    logic [9:0] match_cnt;
    logic walarm_flag;
    logic [7:0] rd_data;
  } rtccal_clk_t;
  // osc domain state
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] len_s1; // first sync stage of sec_len
    logic [15:0] len_s2;
    logic tick_tog; // toggles once per second
  } rtccal_osc_t;
  rtccal_clk_t s, next_s;
  rtccal_osc_t o, next_o;
  // helper nets shared by logic and checks
  logic tick, sec_c, min_c, hour_c, day_c, mon_c, year_c, leap, match_now;
  logic [7:0] last_day;
  // BCD increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // next hour in either mode; 12h uses 12 midnight, 32 noon
  function automatic logic [7:0] hour_inc(input logic [7:0] h, input logic m12);
    if (!m12) begin
      hour_inc = (h == 8'h23) ? 8'h00 : bcd_inc(h);
    end else begin
      case (h)
        8'h11: hour_inc = 8'h32;
        8'h31: hour_inc = 8'h12;
        8'h12: hour_inc = 8'h01;
        8'h32: hour_inc = 8'h21;
        default: hour_inc = bcd_inc(h);
      endcase
    end
  endfunction

  // trimmed length of a corrected second
  function automatic logic [15:0] trim_len(input logic [7:0] t);
    if (t[5:1] == 5'h00) begin
      trim_len = BASE_LEN;
    end else if (!t[TRIM_DIR_BIT]) begin
      trim_len = BASE_LEN + {9'h000, t[5:0] - 6'h01, 1'b0};
    end else begin
      trim_len = BASE_LEN - {9'h000, (~t[5:0]) + 6'h01, 1'b0};
    end
  endfunction

  // leap year: BCD multiple of four, 00 included
  assign leap = s.year[4] ? (s.year[3:0] == 4'h2 || s.year[3:0] == 4'h6)
                          : (s.year[3:0] == 4'h0 || s.year[3:0] == 4'h4 || s.year[3:0] == 4'h8);
  // last day of the current month
  always_comb begin
    case (s.month[4:0])
      5'h02: last_day = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end

  // carry chain; tick is the edge of the synced toggle
  assign tick = s.tick_s2 ^ s.tick_s3;
  assign sec_c = tick && s.sec == 8'h59;
  assign min_c = sec_c && s.min == 8'h59;
  assign hour_c = min_c && (hour_mode_12 ? s.hour == 8'h31 : s.hour == 8'h23);
  assign day_c = hour_c && s.day == last_day;
  assign mon_c = day_c && s.month[4:0] == 5'h12;
  assign year_c = mon_c && s.year == 8'h99;
  // weekday 7 indexes bit 7, which is always zero, so it never matches
  assign match_now = week_alarm_enable && s.min == s.wmin && s.hour == s.whour
                     && s.wdays[s.wday];
  // clk domain next state
  always_comb begin
    logic [7:0] new_sec;
    logic slot;
    new_sec = s.sec;
    slot = 1'b0;
    next_s = s;
    // toggle synchroniser from the oscillator domain
    next_s.tick_s1 = o.tick_tog;
    next_s.tick_s2 = s.tick_s1;
    next_s.tick_s3 = s.tick_s2;
    // timekeeping advance, all counters in BCD
    if (tick) begin
      new_sec = sec_c ? 8'h00 : bcd_inc(s.sec);
      next_s.sec = new_sec;
      if (s.trim[TRIM_SEL_BIT]) begin
        slot = new_sec == 8'h00;
      end else begin
        slot = new_sec == 8'h00 || new_sec == 8'h20 || new_sec == 8'h40;
      end
      // only the count of the selected second changes
      next_s.sec_len = (slot && !s.trim_written) ? trim_len(s.trim) : BASE_LEN;
      next_s.trim_written = 1'b0;
    end
    if (sec_c) begin
      next_s.min = (s.min == 8'h59) ? 8'h00 : bcd_inc(s.min);
    end
    if (min_c) begin
      next_s.hour = hour_inc(s.hour, hour_mode_12);
    end
    if (hour_c) begin
      next_s.wday = (s.wday == 3'h6) ? 3'h0 : s.wday + 3'h1;
      next_s.day = day_c ? RST_ONE : bcd_inc(s.day);
    end
    if (day_c) begin
      next_s.month[4:0] = mon_c ? 5'h01 : 5'(bcd_inc({3'h0, s.month[4:0]}));
    end
    if (mon_c) begin
      next_s.year = year_c ? 8'h00 : bcd_inc(s.year);
    end
    if (year_c) begin
      next_s.month[CENTURY_BIT] = ~s.month[CENTURY_BIT];
    end
    // host writes win over a carry in the same cycle; masks drop unused bits
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SEC: next_s.sec = reg_wdata & MASK_SEC;
        ADDR_MIN: next_s.min = reg_wdata & MASK_MIN;
        ADDR_HOUR: next_s.hour = reg_wdata & MASK_HOUR;
        ADDR_WDAY: next_s.wday = reg_wdata[2:0];
        ADDR_DAY: next_s.day = reg_wdata & MASK_DAY;
        ADDR_MONTH: next_s.month = reg_wdata & MASK_MONTH;
        ADDR_YEAR: next_s.year = reg_wdata;
        ADDR_TRIM: begin
          next_s.trim = reg_wdata;
          next_s.trim_written = 1'b1;
        end
        ADDR_WMIN: next_s.wmin = reg_wdata & MASK_MIN;
        ADDR_WHOUR: next_s.whour = reg_wdata & MASK_HOUR;
        ADDR_WDAYS: next_s.wdays = reg_wdata & MASK_WDAYS;
        default: ; // unmapped writes are ignored
      endcase
    end
    // power-up flag holds trim cleared
    if (power_up_flag) begin
      next_s.trim = RST_ZERO;
    end
    // alarm: delay counter from the rising match, set beats clear
    next_s.match_prev = match_now;
    if (walarm_flag_clear) begin
      next_s.walarm_flag = 1'b0;
    end
    if (match_now && !s.match_prev) begin
      next_s.match_pending = 1'b1;
      next_s.match_cnt = MATCH_LOAD;
    end else if (s.match_pending) begin
      if (!match_now) begin
        next_s.match_pending = 1'b0; // match gone before the delay ran out
      end else if (s.match_cnt == 10'h000) begin
        next_s.match_pending = 1'b0;
        next_s.walarm_flag = 1'b1;
      end else begin
        next_s.match_cnt = s.match_cnt - 10'h001;
      end
    end
    // disabled alarm reads as no match
    if (!week_alarm_enable) begin
      next_s.walarm_flag = 1'b0;
      next_s.match_pending = 1'b0;
    end
    // read data registered, one cycle after the address
    case (reg_addr)
      ADDR_SEC: next_s.rd_data = s.sec;
      ADDR_MIN: next_s.rd_data = s.min;
      ADDR_HOUR: next_s.rd_data = s.hour;
      ADDR_WDAY: next_s.rd_data = {5'h00, s.wday};
      ADDR_DAY: next_s.rd_data = s.day;
      ADDR_MONTH: next_s.rd_data = s.month;
      ADDR_YEAR: next_s.rd_data = s.year;
      ADDR_TRIM: next_s.rd_data = s.trim;
      ADDR_WMIN: next_s.rd_data = s.wmin;
      ADDR_WHOUR: next_s.rd_data = s.whour;
      ADDR_WDAYS: next_s.rd_data = s.wdays;
      default: next_s.rd_data = RST_ZERO; // unmapped reads zero
    endcase
  end

  // clk domain registers; calendar starts at 00-01-01 00:00:00
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.day <= RST_ONE;
      s.month <= RST_ONE;
      s.sec_len <= BASE_LEN;
    end else begin
      s <= next_s;
    end
  end

  // osc domain: second divider; sec_len only changes right after a tick,
  // so it is stable for a whole second before the divider reloads it
  always_comb begin
    next_o = o;
    next_o.len_s1 = s.sec_len;
    next_o.len_s2 = o.len_s1;
    if (o.cnt >= o.len_s2 - 16'h0001) begin
      next_o.cnt = 16'h0000;
      next_o.tick_tog = ~o.tick_tog;
    end else begin
      next_o.cnt = o.cnt + 16'h0001;
    end
  end

  // only the count changes with trim; osc_clk itself passes untouched
  always_ff @(posedge osc_clk or posedge reset) begin
    if (reset) begin
      o <= '0;
      o.len_s1 <= BASE_LEN;
      o.len_s2 <= BASE_LEN;
    end else begin
      o <= next_o;
    end
  end

  assign reg_rd_data = s.rd_data;
  assign walarm_flag = s.walarm_flag;
  // checks
  property p_feb_short;
    @(posedge clk) disable iff (reset)
    hour_c && !reg_wr && s.month[4:0] == 5'h02 && !leap && s.day == 8'h28 |=> s.day == 8'h01;
  endproperty
  a_feb_short: assert property (p_feb_short) else $error("february did not roll after 28");
  property p_month_up;
    @(posedge clk) disable iff (reset)
    day_c && !reg_wr && s.month[4:0] == 5'h04 |=> s.day == 8'h01 && s.month[4:0] == 5'h05;
  endproperty
  a_month_up: assert property (p_month_up) else $error("day roll did not advance month");
  property p_year_up;
    @(posedge clk) disable iff (reset)
    mon_c && !reg_wr && s.year == 8'h99 |=> s.month[4:0] == 5'h01 && s.year == 8'h00;
  endproperty
  a_year_up: assert property (p_year_up) else $error("month roll did not advance year");
  property p_century;
    @(posedge clk) disable iff (reset)
    year_c && !reg_wr |=> s.year == 8'h00 && s.month[CENTURY_BIT] != $past(s.month[CENTURY_BIT]);
  endproperty
  a_century: assert property (p_century) else $error("century bit did not flip");
  property p_trim_clear;
    @(posedge clk) disable iff (reset)
    power_up_flag |=> s.trim == 8'h00;
  endproperty
  a_trim_clear: assert property (p_trim_clear) else $error("trim not cleared by power-up flag");
  property p_trim_twenty;
    @(posedge clk) disable iff (reset)
    tick && s.sec == 8'h19 && s.trim == 8'h21 && !s.trim_written |=> s.sec_len == BASE_LEN + 16'h0040;
  endproperty
  a_trim_twenty: assert property (p_trim_twenty) else $error("second 20 not lengthened by 64");
  property p_trim_skip;
    @(posedge clk) disable iff (reset)
    tick && s.trim_written |=> s.sec_len == BASE_LEN;
  endproperty
  a_trim_skip: assert property (p_trim_skip) else $error("slot corrected despite trim write");
  property p_trim_none;
    @(posedge clk) disable iff (reset)
    tick && s.trim[5:1] == 5'h00 |=> s.sec_len == BASE_LEN;
  endproperty
  a_trim_none: assert property (p_trim_none) else $error("correction with zero trim value");
  property p_weekday;
    @(posedge clk) disable iff (reset)
    hour_c && !reg_wr && s.wday == 3'h6 |=> s.wday == 3'h0;
  endproperty
  a_weekday: assert property (p_weekday) else $error("weekday did not wrap after six");
  property p_flag_late;
    @(posedge clk) disable iff (reset)
    match_now && !s.match_prev && !s.walarm_flag |=> !s.walarm_flag [*8];
  endproperty
  a_flag_late: assert property (p_flag_late) else $error("alarm flag set too early");
  property p_flag_off;
    @(posedge clk) disable iff (reset)
    !week_alarm_enable |=> !s.walarm_flag;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag shown while alarm disabled");
  property p_no_days;
    @(posedge clk) disable iff (reset)
    s.wdays == 8'h00 && !s.walarm_flag |=> !s.walarm_flag;
  endproperty
  a_no_days: assert property (p_no_days) else $error("flag with no day enabled");
  property p_div_wrap;
    @(posedge osc_clk) disable iff (reset)
    o.cnt == o.len_s2 - 16'h0001 |=> o.cnt == 16'h0000 && o.tick_tog != $past(o.tick_tog);
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider did not end the second");
  property p_cov_year;
    @(posedge clk) disable iff (reset) year_c;
  endproperty
  c_cov_year: cover property (p_cov_year);
  property p_cov_flag;
    @(posedge clk) disable iff (reset) $rose(s.walarm_flag);
  endproperty
  c_cov_flag: cover property (p_cov_flag);
  property p_cov_short;
    @(posedge clk) disable iff (reset) tick ##1 s.sec_len < BASE_LEN;
  endproperty
  c_cov_short: cover property (p_cov_short);
endmodule // rtccal_top
`default_nettype wire

/* File: verif/rtccal_host.sv */
// Purpose: host model that drives the byte-wide register port
// Assumes: every change lands 1 ns after a clk rising edge
// Notes: single bytes only, reads wait out the registered answer
`timescale 1ns/1ps
`default_nettype none
module rtccal_host (
  input wire logic clk,
  input wire logic [7:0] reg_rd_data,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr
);
  // idle: unmapped index, strobe low
  initial begin
    reg_addr = 4'hF;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
  end
  // one-cycle strobe; callers also hand in values with unused bits set, as the mask test does
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  // answer is registered, so take it two edges after the address
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    @(posedge clk);
    @(posedge clk);
    #1;
    d = reg_rd_data;
  endtask
endmodule // rtccal_host
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: self-checking bench for calendar, trim and weekly alarm
// Assumes: short second of 256 oscillator counts, free-running oscillator
// Notes: second lengths are timed by polling, so they carry a tolerance
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtccal_pkg::*;
  localparam int SECN = 256; // short second keeps the run brief
  logic clk, reset, osc_clk, hour_mode_12, power_up_flag, week_alarm_enable, walarm_flag_clear;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rd_data, d;
  logic reg_wr, walarm_flag;
  logic [47:0] e;
  int n_errors, compares, n;
  realtime t0;
  // day month year before, then after the carry
  logic [47:0] cal [7] = '{48'h280201010301, 48'h280204290204, 48'h290200010300,
    48'h300401010501, 48'h300101310101, 48'h311299018100, 48'h319299010100};
  // trim, rewrite, start second, timed second, expected counts
  logic [47:0] trm [7] = '{48'h210018200140, 48'h5F00182000BE, 48'h410018200100,
    48'h210118200100, 48'hA10018200100, 48'hA10058000140, 48'h210038400140};
  // mode, hour, weekday, day enables, flag expected
  logic [31:0] alm [4] = '{32'h01003081, 32'h01003000, 32'h01003100, 32'h13206401};
  // index, written value, value read back
  logic [19:0] msk [6] = '{20'h4E525, 20'h57111, 20'h88505, 20'h9C707, 20'hAFF7F, 20'hF5A00};

  rtccal_top #(.SEC_COUNTS(SECN)) dut (.clk(clk), .reset(reset), .osc_clk(osc_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .hour_mode_12(hour_mode_12), .power_up_flag(power_up_flag),
    .week_alarm_enable(week_alarm_enable), .walarm_flag_clear(walarm_flag_clear),
    .reg_rd_data(reg_rd_data), .walarm_flag(walarm_flag));
  rtccal_host h (.clk(clk), .reg_rd_data(reg_rd_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr));

  // 25 MHz system clock
  always #20 clk = ~clk;
  // oscillator at 15 ns, phase offset from clk on purpose
  initial begin
    osc_clk = 1'b0;
    #3.3;
    forever #7.5 osc_clk = ~osc_clk;
  end

  // one comparison, four-state exact
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // polled timing is only good to a few counts, so snap near values
  function automatic logic [15:0] near(input int v, input int x);
    return (v - x <= 12 && x - v <= 12) ? 16'(x) : 16'(v);
  endfunction
  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // poll a register until it equals (eq=1) or leaves (eq=0) a value
  task automatic wait_reg(input logic [3:0] a, input logic [7:0] v, input bit eq);
    logic [7:0] r;
    for (int i = 0; i < 1000; i++) begin
      h.rd(a, r);
      if ((r === v) == eq) return;
    end
    n_errors++;
    $display("[ERR] %0t wait timed out", $time);
    results();
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    hour_mode_12 = 1'b0;
    power_up_flag = 1'b0;
    week_alarm_enable = 1'b0;
    walarm_flag_clear = 1'b0;
    n_errors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    h.rd(ADDR_TRIM, d);
    check(16'(d), 16'h00);
    // trim held clear while the power-up flag stands
    power_up_flag = 1'b1;
    h.wr(ADDR_TRIM, 8'h55);
    h.rd(ADDR_TRIM, d);
    check(16'(d), 16'h00);
    power_up_flag = 1'b0;
    foreach (msk[i]) begin
      h.wr(msk[i][19:16], msk[i][15:8]);
      h.rd(msk[i][19:16], d);
      check(16'(d), 16'(msk[i][7:0]));
    end
    $display("reset and mask test done");
    // end of day carries through month, year and century
    foreach (cal[i]) begin
      e = cal[i];
      h.wr(ADDR_MIN, 8'h59);
      h.wr(ADDR_HOUR, 8'h23);
      h.wr(ADDR_WDAY, 8'h06);
      h.wr(ADDR_DAY, e[47:40]);
      h.wr(ADDR_MONTH, e[39:32]);
      h.wr(ADDR_YEAR, e[31:24]);
      h.wr(ADDR_SEC, 8'h59);
      wait_reg(ADDR_SEC, 8'h00, 1'b1);
      h.rd(ADDR_DAY, d);
      check(16'(d), 16'(e[23:16]));
      h.rd(ADDR_MONTH, d);
      check(16'(d), 16'(e[15:8]));
      h.rd(ADDR_YEAR, d);
      check(16'(d), 16'(e[7:0]));
      h.rd(ADDR_WDAY, d);
      check(16'(d), 16'h00);
    end
    $display("calendar test done");
    // length of the timed second for each trim setting
    foreach (trm[i]) begin
      e = trm[i];
      h.wr(ADDR_TRIM, e[47:40]);
      h.wr(ADDR_SEC, e[31:24]);
      if (e[32]) begin
        wait_reg(ADDR_SEC, e[31:24] + 8'h01, 1'b1);
        h.wr(ADDR_TRIM, e[47:40]);
      end
      wait_reg(ADDR_SEC, e[23:16], 1'b1);
      t0 = $realtime;
      wait_reg(ADDR_SEC, e[23:16], 1'b0);
      n = int'(($realtime - t0) / 15.0);
      check(near(n, int'(e[15:0])), e[15:0]);
    end
    h.wr(ADDR_TRIM, 8'h00);
    $display("trim test done");
    // weekly alarm: match, day masks, noon in 12-hour mode
    week_alarm_enable = 1'b1;
    foreach (alm[i]) begin
      e = 48'(alm[i]);
      hour_mode_12 = e[28];
      h.wr(ADDR_WMIN, 8'h05);
      h.wr(ADDR_WHOUR, e[27:20]);
      h.wr(ADDR_WDAYS, e[11:4]);
      h.wr(ADDR_HOUR, e[27:20]);
      h.wr(ADDR_WDAY, e[19:12]);
      h.wr(ADDR_MIN, 8'h04);
      h.wr(ADDR_SEC, 8'h59);
      walarm_flag_clear = 1'b1;
      @(posedge clk);
      #1;
      walarm_flag_clear = 1'b0;
      wait_reg(ADDR_MIN, 8'h05, 1'b1);
      for (n = 0; n < 900 && walarm_flag !== 1'b1; n++) begin
        @(posedge clk);
        #1;
      end
      if (e[0]) begin
        check(near(n, 773), 16'h0305);
      end else begin
        check(16'(walarm_flag), 16'h0000);
      end
    end
    // flag reads zero once the alarm is disabled
    week_alarm_enable = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(16'(walarm_flag), 16'h0000);
    $display("alarm test done");
    results();
  end
endmodule // testbench
`default_nettype wire
